// ---- monitor_regs_pkg.sv ----
package monitor_regs_pkg;

    // Register indices on the management bus
    localparam logic [7:0] ADDR_VALUE_FIRST = 8'h13;
    localparam logic [7:0] ADDR_VALUE_LAST = 8'h3A;
    localparam logic [7:0] ADDR_TRIP_LOCAL = 8'h13;
    localparam logic [7:0] ADDR_TRIP_REMOTE = 8'h14;
    localparam logic [7:0] ADDR_DEF_TRIP_LOCAL = 8'h17;
    localparam logic [7:0] ADDR_DEF_TRIP_REMOTE = 8'h18;
    localparam logic [7:0] ADDR_REMOTE2_VALUE = 8'h20;
    localparam logic [7:0] ADDR_REMOTE1_VALUE = 8'h26;
    localparam logic [7:0] ADDR_LOCAL_VALUE = 8'h27;
    localparam logic [7:0] ADDR_MAKER_ID = 8'h3E;
    localparam logic [7:0] ADDR_REVISION = 8'h3F;
    localparam logic [7:0] ADDR_CONFIG = 8'h40;
    localparam logic [7:0] ADDR_STATUS = 8'h41;
    localparam logic [7:0] ADDR_RSVD_A = 8'h42;
    localparam logic [7:0] ADDR_MASK = 8'h43;
    localparam logic [7:0] ADDR_RSVD_B = 8'h44;
    localparam logic [7:0] ADDR_RSVD_C = 8'h47;
    localparam logic [7:0] ADDR_RSVD_D = 8'h4A;
    localparam logic [7:0] ADDR_STATUS_COPY = 8'h4C;

    // Value bank size
    localparam int VALUE_COUNT = 40;

    // Reset values
    localparam logic [7:0] CONFIG_RESET = 8'h25;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] STATUS_COPY_RESET = 8'h00;
    localparam logic [7:0] TRIP_LOCAL_RESET = 8'h46;
    localparam logic [7:0] TRIP_REMOTE_RESET = 8'h64;
    localparam logic [7:0] VALUE_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Configuration bit positions
    localparam int CFG_START_BIT = 0;
    localparam int CFG_OUT_EN_BIT = 1;
    localparam int CFG_CLEAR_BIT = 2;
    localparam int CFG_LOCK_BIT = 3;
    localparam int CFG_GPI_INV_BIT = 6;

    // Status bit that follows the logic input, never latched
    localparam int STATUS_GPI_BIT = 4;
    localparam logic [7:0] STATUS_LATCH_MASK = 8'hEF;

    // Revision field positions
    localparam int REV_STEP_LSB = 0;
    localparam int REV_VERSION_LSB = 4;

endpackage

// ---- value_bank.sv ----
module value_bank
    import monitor_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic wrEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] wrData,
    input wire logic tripLock,
    input wire logic [7:0] localTemp,
    input wire logic [7:0] remote1Temp,
    input wire logic [7:0] remote2Temp,
    output logic inRange,
    output logic [7:0] valueRd
);
    logic [7:0] entryQ [VALUE_COUNT];
    logic [7:0] idx;
    logic [5:0] rdIdx;

    assign inRange = (regAddr >= ADDR_VALUE_FIRST) && (regAddr <= ADDR_VALUE_LAST);
    assign idx = regAddr - ADDR_VALUE_FIRST;
    assign rdIdx = idx[5:0];

    genvar i;
    generate
        for (i = 0; i < VALUE_COUNT; i++) begin : g_entry
            localparam logic [7:0] ENTRY_ADDR = ADDR_VALUE_FIRST + 8'(i);
            localparam bit IS_TRIP = (ENTRY_ADDR == ADDR_TRIP_LOCAL) ||
                                     (ENTRY_ADDR == ADDR_TRIP_REMOTE);
            localparam logic [7:0] INIT = (ENTRY_ADDR == ADDR_TRIP_LOCAL) ? TRIP_LOCAL_RESET :
                                          (ENTRY_ADDR == ADDR_TRIP_REMOTE) ? TRIP_REMOTE_RESET :
                                          VALUE_RESET;
            logic hit;
            assign hit = wrEn && inRange && (idx == ENTRY_ADDR - ADDR_VALUE_FIRST) &&
                         !(IS_TRIP && tripLock);
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    entryQ[i] <= INIT;
                end else if (hit) begin
                    entryQ[i] <= wrData;
                end
            end
        end
    endgenerate

    // Read-only locations show live values and fixed trip defaults
    assign valueRd = !inRange ? READ_ZERO :
                     (regAddr == ADDR_DEF_TRIP_LOCAL) ? TRIP_LOCAL_RESET :
                     (regAddr == ADDR_DEF_TRIP_REMOTE) ? TRIP_REMOTE_RESET :
                     (regAddr == ADDR_REMOTE2_VALUE) ? remote2Temp :
                     (regAddr == ADDR_REMOTE1_VALUE) ? remote1Temp :
                     (regAddr == ADDR_LOCAL_VALUE) ? localTemp :
                     entryQ[rdIdx];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_trip_locked: assert property (tripLock && wrEn && regAddr == ADDR_TRIP_LOCAL
        |=> $stable(entryQ[0])) else $error("trip point changed while locked");
    a_trip_open: assert property (!tripLock && wrEn && regAddr == ADDR_TRIP_REMOTE
        |=> entryQ[1] == $past(wrData)) else $error("trip point write lost");
    c_trip_write: cover property (!tripLock && wrEn && regAddr == ADDR_TRIP_LOCAL);
endmodule

// ---- alert_gate.sv ----
module alert_gate
    import monitor_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] statusBits,
    input wire logic [7:0] maskBits,
    input wire logic outEnable,
    input wire logic alertClear,
    output logic alertPinOut,
    output logic alertPinOe
);
    logic pending;
    logic alertOe_q;
    logic alertOe_d;

    assign pending = |(statusBits & ~maskBits);
    assign alertOe_d = outEnable && !alertClear && pending;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            alertOe_q <= 1'b0;
        end else begin
            alertOe_q <= alertOe_d;
        end
    end

    // Open drain, active low: drives zero when enabled
    assign alertPinOut = 1'b0;
    assign alertPinOe = alertOe_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_pin_gated: assert property (alertPinOe |-> $past(outEnable) && !$past(alertClear))
        else $error("alert pin driven without enable");
    a_clear_holds: assert property (alertClear [*2] |-> !alertPinOe)
        else $error("alert pin driven while clear set");
endmodule

// ---- monitor_register_map.sv ----
module monitor_register_map
    import monitor_regs_pkg::*;
#(
    parameter logic [7:0] MAKER_ID = 8'h5A,  // Arbitrary value
    parameter logic [3:0] PART_VERSION = 4'h3,  // Arbitrary value
    parameter logic [3:0] PART_STEPPING = 4'h1  // Arbitrary value
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic wrEn,
    input wire logic [7:0] wrData,
    input wire logic rdEn,
    output logic [7:0] rdData,
    input wire logic [7:0] alertEvent,
    input wire logic gpiPin,
    input wire logic overtempTrip,
    input wire logic [7:0] localTemp,
    input wire logic [7:0] remote1Temp,
    input wire logic [7:0] remote2Temp,
    output logic runEnable,
    output logic alertPinOut,
    output logic alertPinOe,
    output logic overtempOut_b
);
    logic [7:0] config_q;
    logic [7:0] config_d;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] mask_q;
    logic [7:0] mask_d;
    logic [7:0] statusCopy_q;
    logic [7:0] statusCopy_d;
    logic [7:0] rdData_q;
    logic [7:0] rdData_d;
    logic overtemp_q;
    logic gpiMeta_q;
    logic gpiSync_q;
    logic gpiLevel;
    logic [7:0] statusView;
    logic hitConfig;
    logic hitStatus;
    logic hitMask;
    logic hitCopy;
    logic hitReserved;
    logic wrConfig;
    logic wrMask;
    logic rdStatus;
    logic rdCopy;
    logic [7:0] statusClr;
    logic [7:0] copyClr;
    logic [7:0] eventsLatched;
    logic [7:0] revisionWord;
    logic valueHit;
    logic [7:0] valueRd;

    // Address decode
    assign hitConfig = (regAddr == ADDR_CONFIG);
    assign hitStatus = (regAddr == ADDR_STATUS);
    assign hitMask = (regAddr == ADDR_MASK);
    assign hitCopy = (regAddr == ADDR_STATUS_COPY);
    assign hitReserved = (regAddr == ADDR_RSVD_A) || (regAddr == ADDR_RSVD_B) ||
                         (regAddr == ADDR_RSVD_C) || (regAddr == ADDR_RSVD_D);
    assign wrConfig = wrEn && hitConfig;
    assign wrMask = wrEn && hitMask;
    assign rdStatus = rdEn && hitStatus;
    assign rdCopy = rdEn && hitCopy;

    // Lock bit is write once; only reset releases it
    assign config_d = wrConfig ? (wrData | (config_q & (8'h01 << CFG_LOCK_BIT))) : config_q;
    assign mask_d = wrMask ? wrData : mask_q;

    // Logic input level after polarity select
    assign gpiLevel = gpiSync_q ^ config_q[CFG_GPI_INV_BIT];

    // Latched sources are cleared by a read; a new event wins over the clear
    assign eventsLatched = alertEvent & STATUS_LATCH_MASK;
    assign statusClr = rdStatus ? STATUS_LATCH_MASK : 8'h00;
    assign copyClr = rdCopy ? STATUS_LATCH_MASK : 8'h00;
    assign status_d = (status_q & ~statusClr) | eventsLatched;
    assign statusCopy_d = (statusCopy_q & ~copyClr) | eventsLatched;
    assign statusView = (status_q & STATUS_LATCH_MASK) |
                        ({7'h00, gpiLevel} << STATUS_GPI_BIT);

    assign revisionWord = ({4'h0, PART_VERSION} << REV_VERSION_LSB) |
                          ({4'h0, PART_STEPPING} << REV_STEP_LSB);

    // Read selection, eight bits per index
    assign rdData_d = !rdEn ? rdData_q :
                      valueHit ? valueRd :
                      (regAddr == ADDR_MAKER_ID) ? MAKER_ID :
                      (regAddr == ADDR_REVISION) ? revisionWord :
                      hitConfig ? config_q :
                      hitStatus ? statusView :
                      hitMask ? mask_q :
                      hitCopy ? (statusCopy_q | (statusView & ~STATUS_LATCH_MASK)) :
                      READ_ZERO;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            config_q <= CONFIG_RESET;
            status_q <= STATUS_RESET;
            mask_q <= MASK_RESET;
            statusCopy_q <= STATUS_COPY_RESET;
        end else begin
            config_q <= config_d;
            status_q <= status_d;
            mask_q <= mask_d;
            statusCopy_q <= statusCopy_d;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_q <= READ_ZERO;
            overtemp_q <= 1'b0;
        end else begin
            rdData_q <= rdData_d;
            overtemp_q <= overtempTrip;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            gpiMeta_q <= 1'b0;
            gpiSync_q <= 1'b0;
        end else begin
            gpiMeta_q <= gpiPin;
            gpiSync_q <= gpiMeta_q;
        end
    end

    value_bank u_value_bank (
        .mclk(mclk),
        .rst_b(rst_b),
        .wrEn(wrEn),
        .regAddr(regAddr),
        .wrData(wrData),
        .tripLock(config_q[CFG_LOCK_BIT]),
        .localTemp(localTemp),
        .remote1Temp(remote1Temp),
        .remote2Temp(remote2Temp),
        .inRange(valueHit),
        .valueRd(valueRd)
    );

    alert_gate u_alert_gate (
        .mclk(mclk),
        .rst_b(rst_b),
        .statusBits(statusView),
        .maskBits(mask_q),
        .outEnable(config_q[CFG_OUT_EN_BIT]),
        .alertClear(config_q[CFG_CLEAR_BIT]),
        .alertPinOut(alertPinOut),
        .alertPinOe(alertPinOe)
    );

    assign rdData = rdData_q;
    assign runEnable = config_q[CFG_START_BIT];
    assign overtempOut_b = !overtemp_q;

    // Helper: first sampled edge after reset release
    logic seen_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= 1'b1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_idle_after_reset: assert property (!seen_q |-> !alertPinOe)
        else $error("alert pin driven right after reset");
    a_config_reset: assert property (!seen_q |-> config_q == CONFIG_RESET)
        else $error("config word reset value wrong");
    a_status_reset: assert property (!seen_q |-> status_q == STATUS_RESET)
        else $error("status not cleared at reset");
    a_mask_reset: assert property (!seen_q |-> mask_q == MASK_RESET)
        else $error("mask not cleared at reset");
    a_copy_reset: assert property (!seen_q |-> statusCopy_q == STATUS_COPY_RESET)
        else $error("status copy not cleared at reset");
    a_event_recorded: assert property (alertEvent[0] |=> status_q[0] && statusCopy_q[0])
        else $error("alert event not recorded");
    a_enable_path: assert property (wrConfig && wrData[CFG_OUT_EN_BIT]
        && !wrData[CFG_CLEAR_BIT] ##1 (|(statusView & ~mask_q)) [*2] |-> alertPinOe)
        else $error("enabled alert not driven");
    a_clear_silent: assert property (config_q[CFG_OUT_EN_BIT] && config_q[CFG_CLEAR_BIT]
        ##1 config_q[CFG_CLEAR_BIT] |-> !alertPinOe) else $error("pin toggled while clear set");
    a_maker_read: assert property (rdEn && regAddr == ADDR_MAKER_ID
        |=> rdData == MAKER_ID) else $error("maker id read wrong");
    a_revision_read: assert property (rdEn && regAddr == ADDR_REVISION
        |=> rdData[7:4] == PART_VERSION && rdData[3:0] == PART_STEPPING)
        else $error("revision fields wrong");
    a_reserved_zero: assert property (rdEn && hitReserved |=> rdData == READ_ZERO)
        else $error("reserved index not zero");
    a_lock_sticky: assert property (config_q[CFG_LOCK_BIT] |=> config_q[CFG_LOCK_BIT])
        else $error("write-once lock released");
    a_overtemp_free: assert property (overtempTrip && mask_q == 8'hFF
        && config_q[CFG_CLEAR_BIT] |=> !overtempOut_b) else $error("overtemp output masked");
    a_outside_zero: assert property (rdEn && regAddr > ADDR_STATUS_COPY
        |=> rdData == READ_ZERO) else $error("unmapped index not zero");

    c_pin_driven: cover property (alertPinOe);
    c_read_clear: cover property (rdStatus && status_q[0]);
    c_event_and_clear: cover property (rdStatus && alertEvent[0]);
    c_lock_set: cover property (wrConfig && wrData[CFG_LOCK_BIT]);
endmodule

// ---- mgmt_host.sv ----
module mgmt_host (
    input wire logic mclk,
    output logic [7:0] regAddr,
    output logic wrEn,
    output logic [7:0] wrData,
    output logic rdEn,
    input wire logic [7:0] rdData
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        regAddr = 8'h00;
        wrEn = 1'b0;
        wrData = 8'h00;
        rdEn = 1'b0;
    end

    // One write, then bus released with inverted lines
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        regAddr = a;
        wrData = d;
        wrEn = 1'b1;
        @(negedge mclk);
        wrEn = 1'b0;
        regAddr = ~a;
        wrData = ~d;
    endtask

    // One read, data taken a cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        regAddr = a;
        rdEn = 1'b1;
        @(negedge mclk);
        rdEn = 1'b0;
        d = rdData;
        regAddr = ~a;
        wrData = ~wrData;
    endtask
endmodule

// ---- tb.sv ----
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin nMismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module tb;
    import monitor_regs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] regAddr, wrData, rdData, alertEvent;
    logic wrEn, rdEn, runEnable, alertPinOut, alertPinOe, overtempOut_b;
    logic gpiPin = 1'b0;
    logic overtempTrip = 1'b0;
    logic [7:0] localTemp = 8'h31;
    logic [7:0] remote1Temp = 8'h4E;
    logic [7:0] remote2Temp = 8'hB2;
    int nMismatch = 0;
    int checksDone = 0;

    always #5 mclk = ~mclk;
    initial alertEvent = 8'h00;

    mgmt_host host_u (.mclk(mclk), .regAddr(regAddr), .wrEn(wrEn), .wrData(wrData),
        .rdEn(rdEn), .rdData(rdData));

    // Identity values are arbitrary
    monitor_register_map #(.MAKER_ID(8'hA7), .PART_VERSION(4'h6), .PART_STEPPING(4'h2)) dut_u (
        .mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .wrEn(wrEn), .wrData(wrData),
        .rdEn(rdEn), .rdData(rdData), .alertEvent(alertEvent), .gpiPin(gpiPin),
        .overtempTrip(overtempTrip), .localTemp(localTemp), .remote1Temp(remote1Temp),
        .remote2Temp(remote2Temp), .runEnable(runEnable), .alertPinOut(alertPinOut),
        .alertPinOe(alertPinOe), .overtempOut_b(overtempOut_b));

    task automatic conclude;
        $display("Checks %0d, mismatches %0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        host_u.rd(a, v);
        `CHK(v, e)
    endtask

    task automatic pulse(input logic [7:0] ev);
        @(negedge mclk);
        alertEvent = ev;
        @(negedge mclk);
        alertEvent = 8'h00;
    endtask

    task automatic waitPin(input logic e);
        for (int i = 0; i < 6 && alertPinOe !== e; i++) begin
            @(negedge mclk);
        end
        `CHK(alertPinOe, e)
    endtask

    task automatic pinIdle;
        repeat (4) begin
            @(negedge mclk);
            `CHK(alertPinOe, 1'b0)
        end
    endtask

    task automatic resetVals;
        `CHK(alertPinOe, 1'b0)
        `CHK(alertPinOut, 1'b0)
        `CHK(overtempOut_b, 1'b1)
        `CHK(runEnable, 1'b1)
        rdChk(8'h40, 8'h25);
        rdChk(8'h41, 8'h00);
        rdChk(8'h43, 8'h00);
        rdChk(8'h4C, 8'h00);
    endtask

    task automatic idRegs;
        host_u.wr(8'h3E, 8'h00);
        host_u.wr(8'h3F, 8'hFF);
        rdChk(8'h3E, 8'hA7);
        rdChk(8'h3F, {4'h6, 4'h2});
    endtask

    task automatic reservedSlots;
        logic [7:0] tbl[6] = '{8'h42, 8'h44, 8'h47, 8'h4A, 8'h3C, 8'h50};
        foreach (tbl[i]) begin
            host_u.wr(tbl[i], 8'hFF);
            rdChk(tbl[i], 8'h00);
        end
    endtask

    task automatic valueRange;
        rdChk(8'h27, 8'h31);
        rdChk(8'h26, 8'h4E);
        rdChk(8'h20, 8'hB2);
        host_u.wr(8'h2B, 8'h5C);
        host_u.wr(8'h3A, 8'hA3);
        host_u.wr(8'h3B, 8'h77);
        rdChk(8'h2B, 8'h5C);
        rdChk(8'h3A, 8'hA3);
        rdChk(8'h3B, 8'h00);
    endtask

    task automatic alertGate;
        host_u.wr(8'h40, 8'h27);
        pulse(8'h01);
        pinIdle();
        host_u.wr(8'h40, 8'h03);
        waitPin(1'b1);
        host_u.wr(8'h40, 8'h07);
        waitPin(1'b0);
        host_u.wr(8'h40, 8'h03);
        waitPin(1'b1);
        rdChk(8'h41, 8'h01);
        waitPin(1'b0);
        rdChk(8'h41, 8'h00);
        rdChk(8'h4C, 8'h01);
        host_u.wr(8'h43, 8'h01);
        rdChk(8'h43, 8'h01);
        pulse(8'h01);
        pinIdle();
        pulse(8'h02);
        waitPin(1'b1);
        rdChk(8'h41, 8'h03);
        waitPin(1'b0);
        rdChk(8'h4C, 8'h03);
        host_u.wr(8'h43, 8'h00);
    endtask

    task automatic overtemp;
        host_u.wr(8'h40, 8'h27);
        host_u.wr(8'h43, 8'hFF);
        @(negedge mclk);
        overtempTrip = 1'b1;
        @(negedge mclk);
        `CHK(overtempOut_b, 1'b0)
        overtempTrip = 1'b0;
        @(negedge mclk);
        `CHK(overtempOut_b, 1'b1)
        `CHK(alertPinOe, 1'b0)
    endtask

    task automatic tripLock;
        host_u.wr(8'h13, 8'h33);
        rdChk(8'h13, 8'h33);
        host_u.wr(8'h40, 8'h0B);
        host_u.wr(8'h13, 8'h44);
        host_u.wr(8'h14, 8'h55);
        rdChk(8'h13, 8'h33);
        rdChk(8'h14, 8'h64);
        host_u.wr(8'h40, 8'h03);
        host_u.wr(8'h13, 8'h44);
        rdChk(8'h13, 8'h33);
    endtask

    task automatic gpiInput;
        @(negedge mclk);
        gpiPin = 1'b1;
        repeat (4) @(negedge mclk);
        rdChk(8'h41, 8'h10);
        rdChk(8'h41, 8'h10);
        host_u.wr(8'h40, 8'h4B);
        repeat (4) @(negedge mclk);
        rdChk(8'h41, 8'h00);
        gpiPin = 1'b0;
        repeat (4) @(negedge mclk);
        rdChk(8'h4C, 8'h10);
    endtask

    initial begin
        #200000;
        nMismatch++;
        $display("[FAIL] %0t run limit reached", $time);
        conclude();
    end

    initial begin
        repeat (8) @(negedge mclk);
        rst_b = 1'b1;
        resetVals();
        idRegs();
        reservedSlots();
        valueRange();
        alertGate();
        overtemp();
        tripLock();
        gpiInput();
        conclude();
    end
endmodule
